// ==== design/standby_pkg.sv ====
// Shared constants and types for the standby controller
package standby_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int OSC_STAB_NS = 100000;
   localparam int DAC_SETTLE_NS = 3000;

   // Least time in ns to whole clock cycles, never below one
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // ****************************************
   // Sizes
   // ****************************************
   localparam int EXT_PIN_COUNT = 8;
   localparam int PERIPH_REQ_COUNT = 4;

   // ****************************************
   // Types
   // ****************************************
   typedef enum {PH_RUN, PH_STANDBY, PH_OSC_WAIT} phase_e;

   // Clock and function enables toward the rest of the chip
   typedef struct packed {
      logic main_osc_en;
      logic pll_en;
      logic cpu_clk_en;
      logic dma_en;
      logic timer_en;
      logic serial_en;
      logic crc_en;
      logic int_osc_en;
      logic key_int_en;
      logic lvd_en;
      logic intc_normal_en;
      logic watch_timer_en;
   } gate_s;

   // State retention controls
   typedef struct packed {
      logic port_hold;
      logic reg_retain;
      logic rto_hold;
   } hold_s;

   // Release-source disable bits, 1 = disabled
   typedef struct packed {
      logic nmi_pin_dis;
      logic nmi_wdt_dis;
      logic int_dis;
   } wake_dis_s;

endpackage

// ==== design/stop_mode_standby_control.sv ====
// Standby controller for stop and low-voltage stop modes
// Contract
// R1: Stop halts busy ADC, restarts, discards first
// R2: Result from before stop is invalid
// R3: Low-voltage stop: all results around it invalid
// R4: Running DAC halts, pin high impedance
// R5: DAC resumes, drives again after settling
// R6: NMI, watchdog or unmasked interrupts release standby
// R7: Reset pin, watchdog or LVD reset release
// R8: Wait oscillator stabilization before CPU runs; a reset release here goes straight to run without the wait
// R9: Ports and CPU registers retained in standby
// R10: Interrupt controller stops, still detects release
// R11: Real-time output stops, pins held
// R12: Watch timer runs only on selected subclock
// R13: Far end stops clocked serial clock first
// R14: Far end stops async serial clock first
// R15: Low-voltage stop leaves ADC result undefined
// R16: Disabled release requests are ignored
// R17: Gate clocks, keep internal osc, key, LVD
`timescale 1ns/1ps
`default_nettype none
module stop_mode_standby_control
   import standby_pkg::*;
#(
   parameter int OSC_WAIT_NS = OSC_STAB_NS,
   parameter int DAC_WAIT_NS = DAC_SETTLE_NS,
   parameter int EXT_PINS = EXT_PIN_COUNT,
   parameter int PERIPH_REQS = PERIPH_REQ_COUNT
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Processor side
   input wire logic stop_req,
   input wire logic low_voltage_mode,
   input wire wake_dis_s wake_dis,
   input wire logic subclock_used,
   input wire logic watch_sel_subclock,
   // Release sources
   input wire logic nmi_pin,
   input wire logic watchdog_nonmaskable_request,
   input wire logic [EXT_PINS-1:0] external_interrupt_pins,
   input wire logic [EXT_PINS-1:0] ext_int_mask,
   input wire logic [PERIPH_REQS-1:0] periph_req,
   input wire logic [PERIPH_REQS-1:0] periph_mask,
   input wire logic reset_pin_n,
   input wire logic watchdog_reset_request,
   input wire logic low_voltage_detector,
   // Analog-to-digital converter
   input wire logic adc_busy,
   input wire logic adc_result_done,
   input wire logic adc_rearm,
   output logic adc_halt,
   output logic adc_restart,
   output logic adc_result_discard,
   output logic adc_result_invalid,
   // Digital-to-analog converter
   input wire logic dac_enable,
   output logic dac_halt,
   output logic dac_pin_oe_n,
   // Chip-wide controls
   output gate_s gates,
   output hold_s hold,
   output logic standby_active
);

   localparam int OSC_CYC = ns_to_cycles(OSC_WAIT_NS);
   localparam int DAC_CYC = ns_to_cycles(DAC_WAIT_NS);

   if (EXT_PINS < 1 || PERIPH_REQS < 1) begin : g_bad_width
      $error("standby control needs at least one request of each kind");
   end
   if (OSC_WAIT_NS < 0 || DAC_WAIT_NS < 0) begin : g_bad_wait
      $error("standby waits cannot be negative");
   end

   // Unmasked, enabled release request present
   function automatic logic wake_hit(
      input logic nmi, input logic wdt_nmi,
      input logic [EXT_PINS-1:0] ext, input logic [EXT_PINS-1:0] emask,
      input logic [PERIPH_REQS-1:0] per,
      input logic [PERIPH_REQS-1:0] pmask, input wake_dis_s dis);
      logic maskable;
      maskable = (|(ext & ~emask)) | (|(per & ~pmask));
      return (nmi & ~dis.nmi_pin_dis) | (wdt_nmi & ~dis.nmi_wdt_dis)
         | (maskable & ~dis.int_dis);
   endfunction

   // ****************************************
   // Reset release and pin synchronisers
   // ****************************************
   localparam int PW = EXT_PINS + 2;

   logic [1:0] rst_pipe;
   logic rst_n;
   logic [PW-1:0] pin_s1, pin_s2, pin_s3, pin_f;
   logic [PW-1:0] next_pin_f;

   // Two-flop release of the asynchronous reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Accept a change when the second and third stages agree
   always_comb begin
      next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
   end

   // Three-stage pin capture
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= {PW{1'b0}};
         pin_s2 <= {PW{1'b0}};
         pin_s3 <= {PW{1'b0}};
         pin_f <= {PW{1'b0}};
      end else begin
         pin_s1 <= {nmi_pin, ~reset_pin_n, external_interrupt_pins};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_f <= next_pin_f;
      end
   end

   logic nmi_f, reset_pin_f;
   logic [EXT_PINS-1:0] ext_f;
   assign {nmi_f, reset_pin_f, ext_f} = pin_f;

   // ****************************************
   // Standby sequencing
   // ****************************************
   phase_e phase, next_phase;
   logic wake, rst_src, osc_start, osc_done;
   logic dac_settle_start, dac_settling;

   assign wake = wake_hit(nmi_f, watchdog_nonmaskable_request, ext_f,
      ext_int_mask, periph_req, periph_mask, wake_dis); // see R6, R16
   assign rst_src = reset_pin_f | watchdog_reset_request
      | low_voltage_detector; // see R7

   // Phase transitions
   always_comb begin
      next_phase = phase;
      osc_start = 1'b0;
      case (phase)
         PH_RUN: begin
            // A pending request keeps the processor running
            if (stop_req && !wake && !rst_src) begin
               next_phase = PH_STANDBY;
            end
         end
         PH_STANDBY: begin
            if (rst_src) begin
               next_phase = PH_RUN; // see R7
            end else if (wake) begin
               next_phase = PH_OSC_WAIT; // see R6, R16
               osc_start = 1'b1; // see R8
            end
         end
         PH_OSC_WAIT: begin
            if (rst_src || osc_done) begin
               next_phase = PH_RUN; // see R8
            end
         end
         default: next_phase = PH_RUN;
      endcase
   end

   // Phase register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= PH_RUN;
      end else begin
         phase <= next_phase;
      end
   end

   // Oscillation stabilization wait
   wait_timer #(.CYCLES(OSC_CYC)) u_osc_wait (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(osc_start),
      .busy(),
      .done(osc_done)
   );

   // DAC settling wait after release
   wait_timer #(.CYCLES(DAC_CYC)) u_dac_wait (
      .mclk(mclk),
      .rst_n(rst_n),
      .start(dac_settle_start),
      .busy(dac_settling),
      .done()
   );

   // ****************************************
   // Gating, retention and converters
   // ****************************************
   logic entering, leaving, lv_active, next_lv_active;
   gate_s next_gates;
   hold_s next_hold;
   logic adc_was_conv, skip_first, lv_taint, stale;
   logic next_adc_was_conv, next_skip_first, next_lv_taint, next_stale;
   logic next_adc_halt, next_adc_restart, next_adc_discard;
   logic dac_was_on, next_dac_was_on, next_dac_halt, next_dac_oe_n;

   assign entering = (phase == PH_RUN) && (next_phase == PH_STANDBY);
   assign leaving = (phase != PH_RUN) && (next_phase == PH_RUN);
   assign dac_settle_start = leaving && dac_was_on && !rst_src;

   // Next values of chip controls and converter bookkeeping
   always_comb begin
      logic sb;
      sb = (next_phase != PH_RUN);
      next_lv_active = entering ? low_voltage_mode : lv_active;
      next_gates.main_osc_en = !(next_phase == PH_STANDBY); // see R17
      next_gates.pll_en = !sb;
      next_gates.cpu_clk_en = !sb; // see R8
      next_gates.dma_en = !sb;
      next_gates.timer_en = !sb;
      next_gates.serial_en = !sb;
      next_gates.crc_en = !sb;
      next_gates.int_osc_en = 1'b1; // see R17
      next_gates.key_int_en = 1'b1;
      next_gates.lvd_en = 1'b1;
      next_gates.intc_normal_en = !sb; // see R10
      next_gates.watch_timer_en = !sb
         || (subclock_used && watch_sel_subclock); // see R12
      next_hold.port_hold = sb; // see R9
      next_hold.reg_retain = sb; // see R9
      next_hold.rto_hold = sb; // see R11
      // Converter bookkeeping
      next_adc_was_conv = adc_was_conv;
      next_skip_first = skip_first;
      next_lv_taint = lv_taint;
      next_stale = stale;
      next_adc_halt = adc_halt;
      next_adc_restart = 1'b0;
      next_adc_discard = 1'b0;
      next_dac_was_on = dac_was_on;
      next_dac_halt = dac_halt;
      if (entering) begin
         next_adc_was_conv = adc_busy;
         next_adc_halt = 1'b1; // see R1, R3, R15
         next_stale = 1'b1; // see R2, R15
         next_lv_taint = lv_taint | low_voltage_mode; // see R3
         next_dac_was_on = dac_enable;
         next_dac_halt = dac_enable; // see R4
      end else if (leaving) begin
         next_adc_halt = 1'b0;
         next_adc_restart = adc_was_conv && !rst_src; // see R1
         next_skip_first = adc_was_conv && !rst_src; // see R1
         next_adc_was_conv = 1'b0;
         next_dac_halt = 1'b0; // see R5
         next_dac_was_on = dac_settle_start;
      end else if (adc_result_done && phase == PH_RUN) begin
         if (skip_first || lv_taint) begin
            next_adc_discard = 1'b1; // see R1, R3
            next_skip_first = 1'b0;
         end else begin
            next_stale = 1'b0;
         end
      end
      if (rst_src) begin
         next_lv_taint = 1'b0;
         next_skip_first = 1'b0;
      end else if (adc_rearm && phase == PH_RUN && !entering) begin
         next_lv_taint = 1'b0;
      end
      // Pin released in standby and while settling
      next_dac_oe_n = !(dac_enable && !sb && !dac_settling
         && !dac_settle_start); // see R4, R5
   end

   // Control registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lv_active <= 1'b0;
         gates <= '{default: 1'b1};
         hold <= '0;
         adc_was_conv <= 1'b0;
         skip_first <= 1'b0;
         lv_taint <= 1'b0;
         stale <= 1'b0;
         adc_halt <= 1'b0;
         adc_restart <= 1'b0;
         adc_result_discard <= 1'b0;
         dac_was_on <= 1'b0;
         dac_halt <= 1'b0;
         dac_pin_oe_n <= 1'b1;
      end else begin
         lv_active <= next_lv_active;
         gates <= next_gates;
         hold <= next_hold;
         adc_was_conv <= next_adc_was_conv;
         skip_first <= next_skip_first;
         lv_taint <= next_lv_taint;
         stale <= next_stale;
         adc_halt <= next_adc_halt;
         adc_restart <= next_adc_restart;
         adc_result_discard <= next_adc_discard;
         dac_was_on <= next_dac_was_on;
         dac_halt <= next_dac_halt;
         dac_pin_oe_n <= next_dac_oe_n;
      end
   end

   assign adc_result_invalid = stale | lv_taint;
   assign standby_active = (phase != PH_RUN);

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   logic [31:0] wait_len;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_len <= '0;
      end else begin
         wait_len <= (phase == PH_OSC_WAIT) ? wait_len + 32'h1 : 32'h0;
      end
   end

   // Cycles since a settling release, until the DAC pin drives again
   logic dac_track;
   logic [31:0] dac_wait_len;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dac_track <= 1'b0;
         dac_wait_len <= '0;
      end else if (phase == PH_OSC_WAIT && osc_done && !rst_src
         && dac_was_on) begin
         dac_track <= 1'b1;
         dac_wait_len <= '0;
      end else if (dac_track) begin
         dac_track <= dac_enable && dac_pin_oe_n && phase == PH_RUN;
         dac_wait_len <= dac_wait_len + 32'h1;
      end
   end

   sequence s_dac_waiting;
      dac_track && dac_enable && dac_pin_oe_n && phase == PH_RUN;
   endsequence
   sequence s_dac_driving;
      dac_track && dac_enable && !dac_pin_oe_n && phase == PH_RUN;
   endsequence

   a_adc_restart_first: assert property (phase == PH_OSC_WAIT && osc_done
      && !rst_src && adc_was_conv |=> adc_restart && adc_halt == 1'b0
      ##0 skip_first) else $error("ADC not restarted"); // see R1
   a_adc_stale_entry: assert property (entering |=>
      adc_result_invalid) else $error("old result not invalid"); // see R2
   a_adc_lv_discard: assert property (lv_taint && adc_result_done
      && phase == PH_RUN && !entering && !leaving |=> adc_result_discard)
      else $error("low-voltage result kept"); // see R3
   a_dac_hiz_standby: assert property (phase == PH_STANDBY |->
      dac_pin_oe_n && dac_halt == dac_was_on)
      else $error("DAC driven in standby"); // see R4
   a_dac_settle_back: assert property (s_dac_waiting |-> // see R5
      dac_wait_len <= DAC_CYC + 1) else $error("DAC did not return");
   a_dac_not_early: assert property (s_dac_driving |-> // see R5
      dac_wait_len >= DAC_CYC) else $error("DAC driven before settling");
   a_wake_ends: assert property (phase == PH_STANDBY && wake && !rst_src
      |=> phase == PH_OSC_WAIT) else $error("wake ignored"); // see R6
   a_reset_ends: assert property (phase != PH_RUN && rst_src |=>
      phase == PH_RUN) else $error("reset ignored"); // see R7
   a_osc_wait_len: assert property (phase == PH_OSC_WAIT ##1
      phase == PH_RUN && !$past(rst_src) |-> wait_len >= OSC_CYC)
      else $error("stabilization cut short"); // see R8
   a_hold_ports: assert property (phase != PH_RUN |-> hold.port_hold
      && hold.reg_retain && hold.rto_hold)
      else $error("state not held"); // see R9, R11
   a_intc_gated: assert property (phase != PH_RUN |->
      !gates.intc_normal_en && !gates.cpu_clk_en && gates.int_osc_en
      && gates.lvd_en && gates.key_int_en)
      else $error("standby gating wrong"); // see R10, R17
   a_watch_timer: assert property (phase != PH_RUN |->
      gates.watch_timer_en == (subclock_used && watch_sel_subclock))
      else $error("watch timer gating wrong"); // see R12
   a_masked_ignored: assert property (phase == PH_STANDBY && !wake
      && !rst_src |=> phase == PH_STANDBY)
      else $error("standby left without cause"); // see R16

endmodule
`default_nettype wire

// ==== design/wait_timer.sv ====
// One-shot cycle timer used for oscillator and converter settling
`timescale 1ns/1ps
`default_nettype none
module wait_timer
   import standby_pkg::*;
#(
   parameter int CYCLES = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   output logic busy,
   output logic done
);

   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   if (CYCLES < 1) begin : g_bad_cycles
      $error("wait_timer needs CYCLES of at least one");
   end

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_busy;
   logic next_done;

   // Load on start, count to the last cycle, pulse done
   always_comb begin
      next_count = count;
      next_busy = busy;
      next_done = 1'b0;
      if (start) begin
         next_count = '0;
         next_busy = 1'b1;
      end else if (busy) begin
         if (count == LAST) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_count = count + W'(1);
         end
      end
   end

   // Timer registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         busy <= next_busy;
         done <= next_done;
      end
   end

endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench for the standby controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import standby_pkg::*;
   localparam int OSC_CYC = 20;
   localparam int DAC_CYC = 4;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic stop_req = 1'b0;
   logic low_voltage_mode = 1'b0;
   wake_dis_s wake_dis = 3'h0;
   logic subclock_used = 1'b0;
   logic watch_sel_subclock = 1'b0;
   logic [7:0] ext_int_mask = 8'h00;
   logic [3:0] periph_mask = 4'h0;
   logic adc_busy = 1'b0;
   logic adc_result_done = 1'b0;
   logic adc_rearm = 1'b0;
   logic dac_enable = 1'b0;
   logic fire = 1'b0;
   logic [2:0] kind_s = 3'h0;
   logic [2:0] idx_s = 3'h0;
   logic nmi_pin, wdt_nmi, rst_pin_n, wdt_rst, lvd;
   logic [7:0] ext_pins;
   logic [3:0] per_req;
   logic adc_halt, adc_restart, adc_result_discard, adc_result_invalid;
   logic dac_halt, dac_pin_oe_n, standby_active;
   gate_s gates;
   hold_s hold;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int n_restart = 0;
   int unsigned seed = 23;
   // Reference model state
   int m_lv = 0;
   int m_first = 0;
   int m_inval = 0;
   int busy_at = 0;
   int dac_at = 0;
   int rst0 = 0;
   int n;

   // ****************************************
   // Instances
   // ****************************************
   stop_mode_standby_control #(.OSC_WAIT_NS(500), .DAC_WAIT_NS(100))
      u_stop_mode_standby_control (.mclk(mclk), .rstn(rstn),
      .stop_req(stop_req), .low_voltage_mode(low_voltage_mode),
      .wake_dis(wake_dis), .subclock_used(subclock_used),
      .watch_sel_subclock(watch_sel_subclock), .nmi_pin(nmi_pin),
      .watchdog_nonmaskable_request(wdt_nmi),
      .external_interrupt_pins(ext_pins), .ext_int_mask(ext_int_mask),
      .periph_req(per_req), .periph_mask(periph_mask),
      .reset_pin_n(rst_pin_n), .watchdog_reset_request(wdt_rst),
      .low_voltage_detector(lvd), .adc_busy(adc_busy),
      .adc_result_done(adc_result_done), .adc_rearm(adc_rearm),
      .adc_halt(adc_halt), .adc_restart(adc_restart),
      .adc_result_discard(adc_result_discard),
      .adc_result_invalid(adc_result_invalid), .dac_enable(dac_enable),
      .dac_halt(dac_halt), .dac_pin_oe_n(dac_pin_oe_n), .gates(gates),
      .hold(hold), .standby_active(standby_active));
   wake_source_model u_wake_source_model (.mclk(mclk), .fire(fire),
      .kind(kind_s), .idx(idx_s), .nmi_pin(nmi_pin),
      .watchdog_nonmaskable_request(wdt_nmi),
      .external_interrupt_pins(ext_pins), .periph_req(per_req),
      .reset_pin_n(rst_pin_n), .watchdog_reset_request(wdt_rst),
      .low_voltage_detector(lvd));

   // ****************************************
   // Clock, timeout and pulse counting
   // ****************************************
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (adc_restart === 1'b1) n_restart <= n_restart + 1;
      if (cyc == 8000) begin
         err_count++;
         stop_test();
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Compare a design value
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Compare a cycle count against a window
   task automatic chk_cnt(input string what, input int lo, input int hi,
                          input int got);
      num_checks++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   // Enter standby with random converter and watch timer settings
   task automatic enter(input logic lv);
      logic [31:0] r;
      r = rnd();
      repeat (10) @(posedge mclk);
      stop_req <= 1'b1;
      low_voltage_mode <= lv;
      adc_busy <= r[0];
      dac_enable <= r[1];
      subclock_used <= r[2];
      watch_sel_subclock <= r[3];
      @(posedge mclk);
      stop_req <= 1'b0;
      @(negedge mclk);
      chk("standby_active", 32'h1, standby_active);
      chk("gates", 32'h1c | (r[2] & r[3]), gates);
      chk("hold", 32'h7, hold);
      chk("adc_halt", 32'h1, adc_halt);
      chk("dac_halt", r[1], dac_halt);
      chk("dac_pin_oe_n", 32'h1, dac_pin_oe_n);
      chk("adc_result_invalid", 32'h1, adc_result_invalid);
      m_inval = 1;
      if (lv) m_lv = 1;
      busy_at = r[0];
      dac_at = r[1];
      rst0 = n_restart;
   endtask

   // Fire one source with given blocking, count cycles until release
   task automatic wake(input int kind, input logic [2:0] dis,
                       input logic mfull, output int cnt);
      logic [31:0] r;
      r = rnd();
      @(posedge mclk);
      fire <= 1'b1;
      kind_s <= kind[2:0];
      idx_s <= r[2:0];
      wake_dis <= dis;
      ext_int_mask <= mfull ? 8'hff : r[15:8] & ~(8'h01 << r[2:0]);
      periph_mask <= mfull ? 4'hf : r[19:16] & ~(4'h1 << r[1:0]);
      @(posedge mclk);
      fire <= 1'b0;
      cnt = 0;
      while (standby_active === 1'b1 && cnt < 60) begin
         @(negedge mclk);
         cnt++;
      end
   endtask

   // Checks after an interrupt release
   task automatic after_int();
      int m;
      m = 0;
      chk("gates", 32'hfff, gates);
      chk("hold", 32'h0, hold);
      chk("dac_halt", 32'h0, dac_halt);
      chk("adc_halt", 32'h0, adc_halt);
      while (dac_pin_oe_n === 1'b1 && m < 12) begin
         @(negedge mclk);
         m++;
      end
      if (dac_at) chk_cnt("dac settle", DAC_CYC, DAC_CYC + 2, m);
      else chk_cnt("dac idle", 12, 12, m);
      chk_cnt("adc restarts", busy_at, busy_at, n_restart - rst0);
      if (busy_at) m_first = 1;
   endtask

   // One converter result, judged against the model
   task automatic result();
      int d;
      d = m_lv | m_first;
      m_first = 0;
      if (d == 0) m_inval = 0;
      @(posedge mclk);
      adc_result_done <= 1'b1;
      @(posedge mclk);
      adc_result_done <= 1'b0;
      @(negedge mclk);
      chk("adc_result_discard", d, adc_result_discard);
      @(negedge mclk);
      chk("adc_result_invalid", m_inval, adc_result_invalid);
   endtask

   // Verdict
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      repeat (8) @(posedge mclk);
      // Release by each unmasked interrupt source
      for (int k = 0; k < 4; k++) begin
         enter(1'b0);
         wake(k, 3'h0, 1'b0, n);
         chk_cnt("osc wait", OSC_CYC + 1, OSC_CYC + 9, n);
         after_int();
         result();
         result();
      end
      $display("test interrupt release done");
      // Disabled or masked sources leave standby standing
      for (int j = 0; j < 5; j++) begin
         enter(1'b0);
         wake((j == 4) ? 2 : j, (j == 0) ? 3'h4 : (j == 1) ? 3'h2 :
              (j == 4) ? 3'h1 : 3'h0, j != 4, n);
         chk("standby_active", 32'h1, standby_active);
         wake(6, 3'h0, 1'b0, n);
      end
      $display("test blocked sources done");
      // Release by each reset source
      for (int k = 4; k < 7; k++) begin
         enter(1'(rnd() % 2));
         wake(k, 3'h0, 1'b0, n);
         chk_cnt("reset release", 1, 9, n);
         chk("gates", 32'hfff, gates);
         repeat (3) @(negedge mclk);
         chk_cnt("adc restarts", 0, 0, n_restart - rst0);
         m_lv = 0;
         m_first = 0;
         result();
      end
      $display("test reset release done");
      // Low-voltage stop taints every result until rearm
      enter(1'b1);
      wake(1, 3'h0, 1'b0, n);
      chk_cnt("osc wait", OSC_CYC + 1, OSC_CYC + 9, n);
      after_int();
      result();
      result();
      @(posedge mclk);
      adc_rearm <= 1'b1;
      @(posedge mclk);
      adc_rearm <= 1'b0;
      m_lv = 0;
      result();
      $display("test low-voltage stop done");
      // Entry refused while a release request is pending
      repeat (10) @(posedge mclk);
      wake(1, 3'h0, 1'b0, n);
      stop_req <= 1'b1;
      @(posedge mclk);
      stop_req <= 1'b0;
      @(negedge mclk);
      chk("standby_active", 32'h0, standby_active);
      $display("test refused entry done");
      stop_test();
   end
endmodule
`default_nettype wire

// ==== sim/wake_source_model.sv ====
// Behavioural model of the interrupt, watchdog and reset request sources
`timescale 1ns/1ps
`default_nettype none
module wake_source_model
   import standby_pkg::*;
#(
   parameter int HOLD = 6
) (
   // Clock
   input wire logic mclk,
   // Bench command
   input wire logic fire,
   input wire logic [2:0] kind,
   input wire logic [2:0] idx,
   // Request lines
   output logic nmi_pin,
   output logic watchdog_nonmaskable_request,
   output logic [7:0] external_interrupt_pins,
   output logic [3:0] periph_req,
   output logic reset_pin_n,
   output logic watchdog_reset_request,
   output logic low_voltage_detector
);
   int left = 0;
   logic [2:0] k = 3'h0;
   logic [2:0] i = 3'h0;
   logic on;

   // ****************************************
   // Request timing
   // ****************************************
   // Latch a command, then hold the request long enough for pin syncs
   always @(posedge mclk) begin
      if (fire) begin
         left <= HOLD;
         k <= kind;
         i <= idx;
      end else if (left > 0) begin
         left <= left - 1;
      end
   end

   // ****************************************
   // Request lines
   // ****************************************
   // One source at a time; no serial clock is ever driven here
   always_comb begin
      on = (left > 0);
      nmi_pin = on && (k == 3'h0);
      watchdog_nonmaskable_request = on && (k == 3'h1);
      external_interrupt_pins = 8'h00;
      periph_req = 4'h0;
      if (on && k == 3'h2) external_interrupt_pins[i] = 1'b1;
      if (on && k == 3'h3) periph_req[i[1:0]] = 1'b1;
      reset_pin_n = !(on && k == 3'h4);
      watchdog_reset_request = on && (k == 3'h5);
      low_voltage_detector = on && (k == 3'h6);
   end
endmodule
`default_nettype wire
